// ==== hdl/pso_ctrl.sv ====
// Quad detect/class enables, emergency shedding and overpower-cut inhibit
//
// Notes on behaviour
// - Shutdown, power-off, port reset, quad reset clear enables.
// - Emergency shed event clears every port's enables.
// - Manual-mode enable write sets push detect bits.
// - Rank/inhibit register resets zero; rank high nibble.
// - Rank bit one sheds port, only single-level mode.
// - Quad reset clears all rank bits.
// - Emergency input rising registers a shed event.
// - Shed ports get full pushbutton power-off actions.
// - Inhibit acts only in power good state.
// - Inhibit zero cuts on overpower; one keeps power.
// - Overcurrent or disconnect still cut power.
// - Overpower faults still reported with inhibit set.
// - Semi: 01 detect, 11 adds class; auto: 11.
`timescale 1ns/1ps
module pso_ctrl
#(
    parameter int NPORTS = 4
)
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                reset_n,
    // Register access
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    output logic      [7:0]          reg_rdata,
    // Port and quad control
    input  wire logic [2*NPORTS-1:0] port_operating_mode,
    input  wire logic [NPORTS-1:0]   push_power_off,
    input  wire logic [NPORTS-1:0]   port_reset_push,
    input  wire logic                quad_reset,
    input  wire logic                multilevel_rank_enable,
    input  wire logic                emergency_flag_clear,
    // Emergency shutdown pin
    input  wire logic                emergency_shed_input,
    // Port condition
    input  wire logic [NPORTS-1:0]   port_power_good,
    input  wire logic [NPORTS-1:0]   over_two_pair,
    input  wire logic [NPORTS/2-1:0] over_four_pair,
    input  wire logic [NPORTS-1:0]   over_current,
    input  wire logic [NPORTS-1:0]   pd_disconnect,
    // Detection and class control
    output logic      [NPORTS-1:0]   detect_check_run,
    output logic      [NPORTS-1:0]   class_probe_run,
    output logic      [NPORTS-1:0]   auto_power_on_arm,
    output logic      [7:0]          push_detect_probe,
    // Emergency shedding
    output logic                     emergency_shed_flag,
    output logic      [NPORTS-1:0]   shed_power_off,
    // Overpower results
    output logic      [NPORTS-1:0]   port_power_cut,
    output logic      [NPORTS-1:0]   two_pair_overpower_fault,
    output logic      [NPORTS-1:0]   four_pair_overpower_fault
);
    if (NPORTS != pso_pkg::FIELD_W)
    begin : g_check
        $error("pso_ctrl serves exactly four ports per quad");
    end

    localparam logic [3:0] ZERO4 = 4'h0;

    // Registers and next values
    logic [7:0]        class_detect;
    logic [7:0]        next_class_detect;
    logic [7:0]        shed_rank_overpower_keep;
    logic [7:0]        next_shed_rank_overpower_keep;
    logic [7:0]        next_reg_rdata;
    logic [7:0]        next_push_detect_probe;
    logic [3:0]        next_detect_check_run;
    logic [3:0]        next_class_probe_run;
    logic [3:0]        next_auto_power_on_arm;
    logic [3:0]        next_shed_power_off;
    logic              next_emergency_shed_flag;
    // Pin synchroniser
    logic              es_meta;
    logic              es_sync;
    logic              es_prev;
    // Decoded terms
    logic              shed_event;
    logic [3:0]        clear_mask;
    logic [3:0]        manual_mask;
    logic [3:0]        run_mask;
    logic [3:0]        rank;
    logic [3:0]        keep;

    function automatic pso_pkg::pso_mode_t port_mode(input logic [7:0] modes, input int idx);
        port_mode = pso_pkg::pso_mode_t'(modes[2*idx +: 2]);
    endfunction

    assign rank = shed_rank_overpower_keep[pso_pkg::RANK_LSB +: pso_pkg::FIELD_W];
    assign keep = shed_rank_overpower_keep[pso_pkg::KEEP_LSB +: pso_pkg::FIELD_W];

    always_comb
    begin
        shed_event                    = es_sync & ~es_prev;
        next_class_detect             = class_detect;
        next_shed_rank_overpower_keep = shed_rank_overpower_keep;
        next_push_detect_probe        = 8'h00;
        next_reg_rdata                = reg_rdata;
        next_emergency_shed_flag      = emergency_shed_flag;
        // Single-level rank picks ports to shed
        next_shed_power_off           = (shed_event && !multilevel_rank_enable)
                                      ? rank : ZERO4;
        clear_mask                    = ZERO4;
        manual_mask                   = ZERO4;
        run_mask                      = ZERO4;
        for (int i = 0; i < 4; i++)
        begin
            case (port_mode(port_operating_mode, i))
                pso_pkg::PSO_SHUTDOWN: clear_mask[i] = 1'b1;
                pso_pkg::PSO_MANUAL:   manual_mask[i] = 1'b1;
                pso_pkg::PSO_SEMI:     run_mask[i] = 1'b1;
                pso_pkg::PSO_AUTO:     run_mask[i] = 1'b1;
                default:               clear_mask[i] = 1'b1;
            endcase
        end
        clear_mask = clear_mask | push_power_off | port_reset_push
                   | {4{quad_reset}} | {4{shed_event}} | next_shed_power_off;
        // Host write of enables
        if (reg_wr && reg_addr == pso_pkg::DC_ADDR)
        begin
            // Shutdown ports ignore the write
            for (int i = 0; i < 4; i++)
            begin
                if (run_mask[i])
                begin
                    next_class_detect[pso_pkg::CLASS_LSB + i]  =
                        reg_wdata[pso_pkg::CLASS_LSB + i];
                    next_class_detect[pso_pkg::DETECT_LSB + i] =
                        reg_wdata[pso_pkg::DETECT_LSB + i];
                end
            end
            next_push_detect_probe = reg_wdata & {manual_mask, manual_mask};
        end
        if (reg_wr && reg_addr == pso_pkg::SR_ADDR)
            next_shed_rank_overpower_keep = reg_wdata;
        // Automatic clearing overrides the write
        next_class_detect = next_class_detect & ~{clear_mask, clear_mask};
        if (quad_reset)
            next_shed_rank_overpower_keep[pso_pkg::RANK_LSB +: pso_pkg::FIELD_W] = ZERO4;
        // Decode of the pair codes
        for (int i = 0; i < 4; i++)
        begin
            next_detect_check_run[i]  = 1'b0;
            next_class_probe_run[i]   = 1'b0;
            next_auto_power_on_arm[i] = 1'b0;
            case (port_mode(port_operating_mode, i))
                pso_pkg::PSO_SEMI:
                begin
                    next_detect_check_run[i] =
                        {class_detect[pso_pkg::CLASS_LSB + i],
                         class_detect[pso_pkg::DETECT_LSB + i]} == pso_pkg::CODE_DETECT
                        || {class_detect[pso_pkg::CLASS_LSB + i],
                            class_detect[pso_pkg::DETECT_LSB + i]} == pso_pkg::CODE_FULL;
                    next_class_probe_run[i]  =
                        {class_detect[pso_pkg::CLASS_LSB + i],
                         class_detect[pso_pkg::DETECT_LSB + i]} == pso_pkg::CODE_FULL;
                end
                pso_pkg::PSO_AUTO:
                begin
                    next_detect_check_run[i]  =
                        {class_detect[pso_pkg::CLASS_LSB + i],
                         class_detect[pso_pkg::DETECT_LSB + i]} == pso_pkg::CODE_FULL;
                    next_class_probe_run[i]   = next_detect_check_run[i];
                    next_auto_power_on_arm[i] = next_detect_check_run[i];
                end
                default:
                begin
                    next_detect_check_run[i] = 1'b0;
                end
            endcase
        end
        // Sticky flag, set beats clear
        if (emergency_flag_clear)
            next_emergency_shed_flag = 1'b0;
        if (shed_event)
            next_emergency_shed_flag = 1'b1;
        if (reg_rd)
        begin
            case (reg_addr)
                pso_pkg::DC_ADDR: next_reg_rdata = class_detect;
                pso_pkg::SR_ADDR: next_reg_rdata = shed_rank_overpower_keep;
                default:          next_reg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            es_meta                  <= 1'b0;
            es_sync                  <= 1'b0;
            es_prev                  <= 1'b0;
            class_detect             <= pso_pkg::DC_RESET;
            shed_rank_overpower_keep <= pso_pkg::SR_RESET;
            reg_rdata                <= pso_pkg::RDATA_RESET;
            push_detect_probe        <= 8'h00;
            detect_check_run         <= ZERO4;
            class_probe_run          <= ZERO4;
            auto_power_on_arm        <= ZERO4;
            shed_power_off           <= ZERO4;
            emergency_shed_flag      <= 1'b0;
        end
        else
        begin
            es_meta                  <= emergency_shed_input;
            es_sync                  <= es_meta;
            es_prev                  <= es_sync;
            class_detect             <= next_class_detect;
            shed_rank_overpower_keep <= next_shed_rank_overpower_keep;
            reg_rdata                <= next_reg_rdata;
            push_detect_probe        <= next_push_detect_probe;
            detect_check_run         <= next_detect_check_run;
            class_probe_run          <= next_class_probe_run;
            auto_power_on_arm        <= next_auto_power_on_arm;
            shed_power_off           <= next_shed_power_off;
            emergency_shed_flag      <= next_emergency_shed_flag;
        end
    end

    for (genvar g = 0; g < NPORTS; g++)
    begin : g_port
        pso_port_guard u_guard
        (
            .clk                       (clk),
            .reset_n                   (reset_n),
            .power_good                (port_power_good[g]),
            .over_two_pair             (over_two_pair[g]),
            .over_four_pair            (over_four_pair[g/2]),
            .over_current              (over_current[g]),
            .pd_gone                   (pd_disconnect[g]),
            .overpower_cut_inhibit     (keep[g]),
            .power_cut                 (port_power_cut[g]),
            .two_pair_overpower_fault  (two_pair_overpower_fault[g]),
            .four_pair_overpower_fault (four_pair_overpower_fault[g])
        );
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_clear_enables: assert property (
        (((class_detect[7:4] | class_detect[3:0]) & $past(clear_mask)) == ZERO4))
        else $error("enable bits survived a clearing condition");
    a_shed_clears_all: assert property (shed_event |=> class_detect == 8'h00)
        else $error("emergency event left enable bits set");
    a_manual_redirect: assert property (
        (reg_wr && reg_addr == pso_pkg::DC_ADDR) |=>
        push_detect_probe == ($past(reg_wdata) & {$past(manual_mask), $past(manual_mask)}))
        else $error("manual write not redirected to push detect bits");
    a_rank_quad_reset: assert property (quad_reset |=> rank == ZERO4)
        else $error("rank bits not cleared by quad reset");
    a_shed_selects: assert property (
        shed_event |=> shed_power_off ==
        ($past(multilevel_rank_enable) ? ZERO4 : $past(rank)))
        else $error("shed pulse does not match rank bits");
    a_flag_on_pin: assert property (
        (es_sync && !es_prev) |=> emergency_shed_flag)
        else $error("emergency pin rise not registered");
    a_keep_power: assert property (
        ##1 ((port_power_cut & $past(port_power_good) & $past(keep)
        & ~$past(over_current) & ~$past(pd_disconnect)) == ZERO4))
        else $error("inhibited port lost power");
    a_fault_cuts: assert property (
        ##1 ((~port_power_cut & $past(port_power_good)
        & ($past(over_current) | $past(pd_disconnect))) == ZERO4))
        else $error("overcurrent or disconnect did not cut power");
    a_fault_reported: assert property (
        ($rose(port_power_good[0] && over_two_pair[0]) && keep[0])
        |=>
        two_pair_overpower_fault[0])
        else $error("overpower fault not reported with inhibit set");
    a_auto_code: assert property (
        (port_mode(port_operating_mode, 0) == pso_pkg::PSO_AUTO
         && class_detect[4:4] == 1'b0) |=> !detect_check_run[0])
        else $error("auto mode ran detection without full code");
endmodule

// ==== hdl/pso_pkg.sv ====
// Constants and types for the port shed and overpower control block
package pso_pkg;
    // Register offsets
    localparam logic [7:0] DC_ADDR     = 8'h14;
    localparam logic [7:0] SR_ADDR     = 8'h15;
    // Reset values
    localparam logic [7:0] DC_RESET    = 8'h00;
    localparam logic [7:0] SR_RESET    = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    // Field positions (four bits each)
    localparam int         CLASS_LSB   = 4;
    localparam int         DETECT_LSB  = 0;
    localparam int         RANK_LSB    = 4;
    localparam int         KEEP_LSB    = 0;
    localparam int         FIELD_W     = 4;
    // Class/detect pair codes
    localparam logic [1:0] CODE_DETECT = 2'h1;
    localparam logic [1:0] CODE_FULL   = 2'h3;
    // Port operating modes
    typedef enum logic [1:0] {
        PSO_SHUTDOWN = 2'b00,
        PSO_MANUAL   = 2'b01,
        PSO_SEMI     = 2'b10,
        PSO_AUTO     = 2'b11
    } pso_mode_t;
endpackage

// ==== hdl/pso_port_guard.sv ====
// Per-port overpower, overcurrent and disconnect power-cut decision
`timescale 1ns/1ps
module pso_port_guard
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Port condition
    input  wire logic power_good,
    input  wire logic over_two_pair,
    input  wire logic over_four_pair,
    input  wire logic over_current,
    input  wire logic pd_gone,
    input  wire logic overpower_cut_inhibit,
    // Results
    output logic      power_cut,
    output logic      two_pair_overpower_fault,
    output logic      four_pair_overpower_fault
);
    logic prev_2p;
    logic prev_4p;
    logic next_power_cut;
    logic next_fault_2p;
    logic next_fault_4p;
    logic over_2p_pg;
    logic over_4p_pg;

    always_comb
    begin
        // Inhibit only matters in power good
        over_2p_pg     = power_good & over_two_pair;
        over_4p_pg     = power_good & over_four_pair;
        next_power_cut = power_good & (over_current | pd_gone
                       | ((over_2p_pg | over_4p_pg) & ~overpower_cut_inhibit));
        // Faults reported whatever the inhibit says
        next_fault_2p  = over_2p_pg & ~prev_2p;
        next_fault_4p  = over_4p_pg & ~prev_4p;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prev_2p                   <= 1'b0;
            prev_4p                   <= 1'b0;
            power_cut                 <= 1'b0;
            two_pair_overpower_fault  <= 1'b0;
            four_pair_overpower_fault <= 1'b0;
        end
        else
        begin
            prev_2p                   <= over_2p_pg;
            prev_4p                   <= over_4p_pg;
            power_cut                 <= next_power_cut;
            two_pair_overpower_fault  <= next_fault_2p;
            four_pair_overpower_fault <= next_fault_4p;
        end
    end
endmodule

// ==== verif/pso_host_model.sv ====
// Host model driving the strobe register port of the control block
`timescale 1ns/1ps
module pso_host_model
(
    // Clock
    input  wire logic       clk,
    // Register access
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata
);
    logic [7:0] exp_q[$];

    initial
    begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // Idle cycle first, so back-to-back calls never retoggle a strobe
    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk);
        reg_wr    = 1'b1;
        reg_addr  = addr;
        reg_wdata = data;
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_addr  = ~addr;
        reg_wdata = ~data;
    endtask

    // Notes the expected read data, then strobes one read
    task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
        exp_q.push_back(exp);
        @(negedge clk);
        reg_rd   = 1'b1;
        reg_addr = addr;
        @(negedge clk);
        reg_rd   = 1'b0;
        reg_addr = ~addr;
    endtask
endmodule

// ==== verif/pse_port_shed_and_overpower_ctrl_tb.sv ====
// Self-checking bench for the port shed and overpower control block
`timescale 1ns/1ps
module pse_port_shed_and_overpower_ctrl_tb;
    logic       clk = 1'b0;
    logic       reset_n;
    logic [7:0] mode;
    logic [3:0] pb_off;
    logic [3:0] prst;
    logic       quad_reset;
    logic       mlr;
    logic       flag_clr;
    logic       es_in;
    logic [3:0] pg;
    logic [3:0] o2;
    logic [1:0] o4;
    logic [3:0] oc;
    logic [3:0] disc;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [7:0] pdp;
    logic [3:0] det;
    logic [3:0] cls;
    logic [3:0] arm;
    logic [3:0] shed;
    logic [3:0] cut;
    logic [3:0] f2;
    logic [3:0] f4;
    logic       esf;
    logic       took = 1'b0;
    logic [7:0] r;
    int         failures = 0;
    int         check_count = 0;

    pso_host_model host_u (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata));

    pso_ctrl #(.NPORTS(4)) dut_u (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .port_operating_mode(mode), .push_power_off(pb_off), .port_reset_push(prst),
        .quad_reset(quad_reset), .multilevel_rank_enable(mlr), .emergency_flag_clear(flag_clr),
        .emergency_shed_input(es_in), .port_power_good(pg), .over_two_pair(o2),
        .over_four_pair(o4), .over_current(oc), .pd_disconnect(disc), .detect_check_run(det),
        .class_probe_run(cls), .auto_power_on_arm(arm), .push_detect_probe(pdp),
        .emergency_shed_flag(esf), .shed_power_off(shed), .port_power_cut(cut),
        .two_pair_overpower_fault(f2), .four_pair_overpower_fault(f4));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("failures %0d checks %0d", failures, check_count);
        if (failures == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Read data compared with the oldest note
    always @(posedge clk) took <= reg_rd;
    always @(negedge clk)
    begin
        if (took)
            check(reg_rdata, host_u.exp_q.pop_front());
    end

    initial
    begin
        #(3000 * 40);
        failures++;
        complete_run();
    end

    initial
    begin
        {mode, pb_off, prst, quad_reset, mlr, flag_clr, es_in} = '0;
        {pg, o2, o4, oc, disc} = '0;
        reset_n = 1'b0;
        void'($urandom(32'h4a09a791));
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        host_u.reg_read(pso_pkg::DC_ADDR, pso_pkg::DC_RESET);
        host_u.reg_read(pso_pkg::SR_ADDR, pso_pkg::SR_RESET);
        host_u.reg_read(8'h3C, 8'h00);
        r = 8'($urandom);
        host_u.reg_write(pso_pkg::SR_ADDR, r);
        host_u.reg_read(pso_pkg::SR_ADDR, r);
        // Semi then auto decode
        mode = 8'hAA;
        host_u.reg_write(pso_pkg::DC_ADDR, 8'h1F);
        @(negedge clk);
        check(8'(det), 8'h0F);
        check(8'(cls), 8'h01);
        check(8'(arm), 8'h00);
        mode = 8'hFF;
        host_u.reg_write(pso_pkg::DC_ADDR, 8'hFF);
        @(negedge clk);
        check({det, cls}, 8'hFF);
        check(8'(arm), 8'h0F);
        // Per-port clearing causes
        pb_off = 4'h2;
        @(negedge clk);
        pb_off = 4'h0;
        host_u.reg_read(pso_pkg::DC_ADDR, 8'hDD);
        prst = 4'h4;
        @(negedge clk);
        prst = 4'h0;
        host_u.reg_read(pso_pkg::DC_ADDR, 8'h99);
        mode = 8'h3F;
        @(negedge clk);
        host_u.reg_read(pso_pkg::DC_ADDR, 8'h11);
        // Quad reset beats a same-cycle write
        mode = 8'hFF;
        host_u.reg_write(pso_pkg::SR_ADDR, 8'hF5);
        quad_reset = 1'b1;
        host_u.reg_write(pso_pkg::DC_ADDR, 8'hFF);
        quad_reset = 1'b0;
        host_u.reg_read(pso_pkg::DC_ADDR, 8'h00);
        host_u.reg_read(pso_pkg::SR_ADDR, 8'h05);
        // Manual and shutdown writes
        mode = 8'h55;
        host_u.reg_write(pso_pkg::DC_ADDR, 8'h21);
        check(pdp, 8'h21);
        mode = 8'h00;
        host_u.reg_write(pso_pkg::DC_ADDR, 8'hFF);
        check(pdp, 8'h00);
        host_u.reg_read(pso_pkg::DC_ADDR, 8'h00);
        // Emergency shedding, single-level then multilevel
        mode = 8'hFF;
        host_u.reg_write(pso_pkg::SR_ADDR, 8'h50);
        for (int k = 0; k < 2; k++)
        begin
            mlr = k[0];
            host_u.reg_write(pso_pkg::DC_ADDR, 8'hFF);
            es_in = 1'b1;
            for (int n = 0; n < 10 && esf !== 1'b1; n++)
                @(negedge clk);
            check(8'(esf), 8'h01);
            check(8'(shed), (k == 0) ? 8'h05 : 8'h00);
            host_u.reg_read(pso_pkg::DC_ADDR, 8'h00);
            es_in = 1'b0;
            flag_clr = 1'b1;
            @(negedge clk);
            flag_clr = 1'b0;
            @(negedge clk);
            check(8'(esf), 8'h00);
        end
        // Overpower with ports 0 and 2 inhibited
        host_u.reg_write(pso_pkg::SR_ADDR, 8'h05);
        pg = 4'hF;
        o2 = 4'hF;
        @(negedge clk);
        check(8'(cut), 8'h0A);
        check(8'(f2), 8'h0F);
        oc = 4'h1;
        @(negedge clk);
        check(8'(cut), 8'h0B);
        check(8'(f2), 8'h00);
        oc = 4'h0;
        disc = 4'h4;
        @(negedge clk);
        check(8'(cut), 8'h0E);
        disc = 4'h0;
        o2 = 4'h0;
        @(negedge clk);
        check(8'(cut), 8'h00);
        o4 = 2'b10;
        @(negedge clk);
        check(8'(f4), 8'h0C);
        check(8'(cut), 8'h08);
        pg = 4'h0;
        @(negedge clk);
        check(8'(cut), 8'h00);
        complete_run();
    end
endmodule
